// *** hw/dwd_pkg.sv ***
// constants shared by the word decoder, its serial receiver and the sine stage
// assumes one 125 MHz clock and a synchronous active-high reset
package dwd_pkg;
   // datapath widths
   localparam int FW = 28;
   localparam int HW = 14;
   localparam int PW = 12;
   localparam int CW = 10;
   localparam int WB = 16;
   localparam logic [4:0] WORD_BITS = 5'h10;
   // destination codes in the two top bits of a word
   localparam logic [1:0] DST_CTRL = 2'h0;
   localparam logic [1:0] DST_TWA = 2'h1;
   localparam logic [1:0] DST_TWB = 2'h2;
   localparam logic [1:0] DST_PH = 2'h3;
   // control and phase word bit positions
   localparam int B_FULL = 13;
   localparam int B_HALF = 12;
   localparam int B_TSEL = 11;
   localparam int B_PSEL = 10;
   localparam int B_RST = 8;
   localparam int B_CSLP = 7;
   localparam int B_DSLP = 6;
   localparam int B_BITEN = 5;
   localparam int B_DIV = 3;
   localparam int B_MODE = 1;
   localparam int B_PHSEL = 13;
   // control starts with the accumulator held in reset
   localparam logic [15:0] CTRL_INIT = 16'h0100;
   // output codes and pipeline depth behind the waveform stage
   localparam logic [9:0] MID = 10'h200;
   localparam logic [9:0] ONES = 10'h3FF;
   localparam int DLY = 3;
   // register map, byte addresses
   localparam logic [7:0] A_WORD = 8'h00;
   localparam logic [7:0] A_CTRL = 8'h04;
   localparam logic [7:0] A_TWA = 8'h08;
   localparam logic [7:0] A_TWB = 8'h0C;
   localparam logic [7:0] A_PHA = 8'h10;
   localparam logic [7:0] A_PHB = 8'h14;
   localparam logic [7:0] A_ACC = 8'h18;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // output selection
   typedef enum logic [1:0] {
      SEL_SINE = 2'b00,
      SEL_TRI = 2'b01,
      SEL_BIT = 2'b10,
      SEL_RSV = 2'b11
   } dwd_sel_t;
endpackage

// *** hw/dwd_serial_rx.sv ***
// three-wire serial word receiver, oversampled on the system clock
// assumes the serial clock is well below a quarter of the system clock
`timescale 1ns/10ps
module dwd_serial_rx (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic frame_sync_n_n,
   input wire logic serial_in,
   output logic [15:0] word,
   output logic word_valid
);
   logic [2:0] sclk_reg;
   logic [2:0] fs_reg;
   logic [1:0] sd_reg;
   logic [4:0] cnt_reg;
   logic sclk_fall;
   logic fs_rise;

   // two flops per pin, a third stage only for edge detection
   always_ff @(posedge clk) begin
      if (reset) begin
         sclk_reg <= 3'h0;
         fs_reg <= 3'h7;
         sd_reg <= 2'h0;
      end else begin
         sclk_reg <= {sclk_reg[1:0], sclk};
         fs_reg <= {fs_reg[1:0], frame_sync_n_n};
         sd_reg <= {sd_reg[0], serial_in};
      end
   end
   assign sclk_fall = sclk_reg[2] & ~sclk_reg[1];
   assign fs_rise = ~fs_reg[2] & fs_reg[1];

   // shift msb first; bits past sixteen are dropped
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= 5'h0;
         word <= 16'h0000;
         word_valid <= 1'b0;
      end else begin
         word_valid <= fs_rise && cnt_reg == dwd_pkg::WORD_BITS; // see (R21)
         if (fs_reg[1]) begin
            cnt_reg <= 5'h0;
         end else if (sclk_fall && cnt_reg != dwd_pkg::WORD_BITS) begin
            cnt_reg <= cnt_reg + 5'h1;
            word <= {word[14:0], sd_reg[1]};
         end
      end
   end

   property p_short_frame;
      @(posedge clk) disable iff (reset)
      fs_rise && cnt_reg != dwd_pkg::WORD_BITS |=> !word_valid;
   endproperty
   a_short_frame: assert property (p_short_frame) // see (R21)
      else $error("short frame produced a word");
endmodule

// *** hw/dwd_sine.sv ***
// sine amplitude stage: half-wave parabola around midscale, one register deep
// assumes the phase input is stable while adv is low
`timescale 1ns/10ps
module dwd_sine (
   input wire logic clk,
   input wire logic reset,
   input wire logic adv,
   input wire logic [11:0] phase,
   output logic [9:0] code
);
   logic [10:0] x;
   logic [22:0] prod;
   logic [9:0] mag;

   // parabola keeps the table to a multiplier instead of a rom
   assign x = phase[10:0];
   assign prod = 23'(x) * 23'(12'h800 - {1'b0, x});
   assign mag = (prod[21:11] > 11'h1FF) ? 10'h1FF : prod[20:11];

   always_ff @(posedge clk) begin
      if (reset) begin
         code <= dwd_pkg::MID;
      end else if (adv) begin
         code <= phase[11] ? dwd_pkg::MID - mag : dwd_pkg::MID + mag; // see (R16)
      end
   end

   property p_sine_zero;
      @(posedge clk) disable iff (reset)
      adv && phase == 12'h000 |=> code == dwd_pkg::MID;
   endproperty
   a_sine_zero: assert property (p_sine_zero) // see (R16)
      else $error("sine of zero phase not midscale");
endmodule

// *** hw/dwd_top.sv ***
// word decoder, phase accumulator and output selection of the waveform core
// assumes serial pins from off chip and an axi4-lite master on CLK
// ****************************************************************
// Behaviour
// (R1) top bits 01 load tuning word a, 10 tuning word b, payload bits 13..0
// (R2) full-width mode: two writes, low 14 bits then high 14 bits
// (R3) top bits 00 form a control word; bit 13 full-width, bit 12 half select
// (R4) half-width mode: half select picks which 14-bit half a write updates
// (R5) host should alternate tuning words for sweeps to avoid glitches
// (R6) top bits 11 load phase offset; bit 13 picks a or b, 12 bits value
// (R7) reset bit clears the accumulator, output midscale, registers kept
// (R8) signal reaches the output seven cycles after reset bit clears
// (R9) host holds reset bit while loading registers, then clears it
// (R10) clock sleep freezes accumulator and holds the output value
// (R11) dac sleep powers down the converter independent of clock sleep
// (R12) words are still decoded while clock sleep is set
// (R13) bit enable and mode pick sine, triangle or msb output
// (R14) divide select picks msb when 1, msb halved when 0
// (R15) triangle mode bypasses the sine stage, 10-bit linear ramp
// (R16) sine mode passes accumulator plus offset through the sine stage
// (R17) tuning select picks which tuning word increments the accumulator
// (R18) phase select picks which phase offset adds to the accumulator
// (R19) host frames sixteen bits msb first with frame sync low
// (R20) full-width mode keeps a per-register low/high toggle flag
// (R21) a word is applied after frame sync rises, short frames dropped
// ****************************************************************
`timescale 1ns/10ps
module dwd_top (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic SCLK,
   input wire logic FRAME_SYNC_N_N,
   input wire logic SERIAL_IN,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [9:0] WAVE_OUT,
   output logic DAC_OFF
);
   // ****************************************************************
   // serial word source
   // ****************************************************************
   logic [15:0] ser_word;
   logic ser_valid;

   dwd_serial_rx u_rx (
      .clk(CLK),
      .reset(RESET),
      .sclk(SCLK),
      .frame_sync_n_n(FRAME_SYNC_N_N),
      .serial_in(SERIAL_IN),
      .word(ser_word),
      .word_valid(ser_valid)
   );

   // ****************************************************************
   // axi4-lite slave
   // ****************************************************************
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [15:0] w_data_reg;
   logic [1:0] w_strb_reg;
   logic axi_do;
   logic inj_valid;
   logic [15:0] last_word_reg;

   // map check, used by both the write and the read side
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = a == dwd_pkg::A_WORD || a == dwd_pkg::A_CTRL ||
         a == dwd_pkg::A_TWA || a == dwd_pkg::A_TWB ||
         a == dwd_pkg::A_PHA || a == dwd_pkg::A_PHB ||
         a == dwd_pkg::A_ACC;
   endfunction

   // a serial word owns the decoder this cycle, so the bus write waits
   assign axi_do = aw_hold_reg && w_hold_reg && !S_AXI_BVALID && !ser_valid;
   assign inj_valid = axi_do && aw_addr_reg == dwd_pkg::A_WORD &&
      w_strb_reg == 2'h3;

   // address and data are taken independently, in either order
   always_ff @(posedge CLK) begin
      if (RESET) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 16'h0000;
         w_strb_reg <= 2'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'h0};
         end else if (axi_do) begin
            aw_hold_reg <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA[15:0];
            w_strb_reg <= S_AXI_WSTRB[1:0];
         end else if (axi_do) begin
            w_hold_reg <= 1'b0;
         end
         S_AXI_AWREADY <= !aw_hold_reg && !(S_AXI_AWVALID && S_AXI_AWREADY);
         S_AXI_WREADY <= !w_hold_reg && !(S_AXI_WVALID && S_AXI_WREADY);
      end
   end

   // write response follows the register update
   always_ff @(posedge CLK) begin
      if (RESET) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= dwd_pkg::RESP_OK;
      end else if (axi_do) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= is_mapped(aw_addr_reg) ? dwd_pkg::RESP_OK : dwd_pkg::RESP_ERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // ****************************************************************
   // word decode and register file
   // ****************************************************************
   logic dec_valid;
   logic [15:0] dec_word;
   logic [15:0] ctrl_reg;
   logic [27:0] tw_reg [2];
   logic [1:0] hi_flag_reg;
   logic [11:0] ph_reg [2];
   logic is_ctrl;
   logic rst_bit;
   logic run;

   // serial and bus-injected words share one decoder
   assign dec_valid = ser_valid || inj_valid;
   assign dec_word = ser_valid ? ser_word : w_data_reg;
   assign is_ctrl = dec_valid && dec_word[15:14] == dwd_pkg::DST_CTRL;
   assign rst_bit = ctrl_reg[dwd_pkg::B_RST];
   assign run = !ctrl_reg[dwd_pkg::B_CSLP]; // see (R10)

   // decoding ignores sleep, so writes land while the clock is gated
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_reg <= dwd_pkg::CTRL_INIT;
         last_word_reg <= 16'h0000;
      end else if (dec_valid) begin
         last_word_reg <= dec_word; // see (R12)
         if (is_ctrl) begin
            ctrl_reg <= {2'h0, dec_word[13:0]}; // see (R3)
         end
      end
   end

   // two tuning words; each holds its own low/high toggle
   for (genvar i = 0; i < 2; i++) begin : g_tw
      localparam logic [1:0] DST = (i == 0) ? dwd_pkg::DST_TWA : dwd_pkg::DST_TWB;
      logic hit;
      logic hi;
      assign hit = dec_valid && dec_word[15:14] == DST; // see (R1)
      // full width follows the toggle, else the half select bit
      assign hi = ctrl_reg[dwd_pkg::B_FULL] ? hi_flag_reg[i] :
         ctrl_reg[dwd_pkg::B_HALF]; // see (R4)

      always_ff @(posedge CLK) begin
         if (RESET) begin
            tw_reg[i] <= 28'h0000000;
         end else if (hit && hi) begin
            tw_reg[i][27:14] <= dec_word[13:0]; // see (R2)
         end else if (hit) begin
            tw_reg[i][13:0] <= dec_word[13:0];
         end
      end

      // a control word restarts the pair at the low half
      always_ff @(posedge CLK) begin
         if (RESET || is_ctrl) begin
            hi_flag_reg[i] <= 1'b0;
         end else if (hit && ctrl_reg[dwd_pkg::B_FULL]) begin
            hi_flag_reg[i] <= !hi_flag_reg[i]; // see (R20)
         end
      end
   end

   // phase offsets; bit 12 of the word is a don't-care
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ph_reg[0] <= 12'h000;
         ph_reg[1] <= 12'h000;
      end else if (dec_valid && dec_word[15:14] == dwd_pkg::DST_PH) begin
         ph_reg[dec_word[dwd_pkg::B_PHSEL]] <= dec_word[11:0]; // see (R6)
      end
   end

   // ****************************************************************
   // accumulator and phase stage
   // ****************************************************************
   logic [27:0] acc_reg;
   logic acc_live_reg;
   logic [11:0] phase_reg;
   logic ph_live_reg;

   // increment from the selected tuning word; reset bit clears it
   always_ff @(posedge CLK) begin
      if (RESET) begin
         acc_reg <= 28'h0000000;
         acc_live_reg <= 1'b0;
      end else if (run) begin
         acc_live_reg <= !rst_bit;
         if (rst_bit) begin
            acc_reg <= 28'h0000000; // see (R7)
         end else begin
            acc_reg <= acc_reg + tw_reg[ctrl_reg[dwd_pkg::B_TSEL]]; // see (R17)
         end
      end
   end

   // top twelve accumulator bits plus the selected offset
   always_ff @(posedge CLK) begin
      if (RESET) begin
         phase_reg <= 12'h000;
         ph_live_reg <= 1'b0;
      end else if (run) begin
         phase_reg <= acc_reg[27:16] + ph_reg[ctrl_reg[dwd_pkg::B_PSEL]]; // see (R18)
         ph_live_reg <= acc_live_reg && !rst_bit;
      end
   end

   // ****************************************************************
   // waveform stage and delay line
   // ****************************************************************
   logic [9:0] sin_code;
   logic [9:0] tri_reg;
   logic msb_reg;
   logic wv_live_reg;
   logic [11:0] dly_reg [dwd_pkg::DLY + 1];

   dwd_sine u_sine (
      .clk(CLK),
      .reset(RESET),
      .adv(run),
      .phase(phase_reg),
      .code(sin_code)
   );

   // fold the top phase bit into a linear up/down ramp
   always_ff @(posedge CLK) begin
      if (RESET) begin
         tri_reg <= 10'h000;
         msb_reg <= 1'b0;
         wv_live_reg <= 1'b0;
      end else if (run) begin
         tri_reg <= phase_reg[11] ? ~phase_reg[10:1] : phase_reg[10:1]; // see (R15)
         msb_reg <= phase_reg[11];
         wv_live_reg <= ph_live_reg && !rst_bit;
      end
   end

   // stage 0 selects sine or ramp; the line only adds latency
   assign dly_reg[0] = {wv_live_reg && !rst_bit, msb_reg,
      ctrl_reg[dwd_pkg::B_MODE] ? tri_reg : sin_code};

   for (genvar k = 1; k <= dwd_pkg::DLY; k++) begin : g_dly
      always_ff @(posedge CLK) begin
         if (RESET) begin
            dly_reg[k] <= {2'h0, dwd_pkg::MID};
         end else if (run) begin
            dly_reg[k] <= {dly_reg[k-1][11] && !rst_bit, dly_reg[k-1][10:0]};
         end
      end
   end

   // ****************************************************************
   // output selection
   // ****************************************************************
   dwd_pkg::dwd_sel_t sel;
   logic [11:0] tail;
   logic msb_prev_reg;
   logic half_reg;
   logic out_live_reg;
   logic [9:0] out_next;

   assign tail = dly_reg[dwd_pkg::DLY];
   assign sel = dwd_pkg::dwd_sel_t'({ctrl_reg[dwd_pkg::B_BITEN], ctrl_reg[dwd_pkg::B_MODE]});

   // halved square: toggle on each rising msb
   always_ff @(posedge CLK) begin
      if (RESET) begin
         msb_prev_reg <= 1'b0;
         half_reg <= 1'b0;
      end else if (run) begin
         msb_prev_reg <= tail[10];
         if (!tail[11]) begin
            half_reg <= 1'b0;
         end else if (tail[10] && !msb_prev_reg) begin
            half_reg <= !half_reg; // see (R14)
         end
      end
   end

   // the reserved pairing parks the output at midscale
   always_comb begin
      unique case (sel)
         dwd_pkg::SEL_SINE: out_next = tail[9:0];
         dwd_pkg::SEL_TRI: out_next = tail[9:0];
         dwd_pkg::SEL_BIT: begin
            if (ctrl_reg[dwd_pkg::B_DIV] ? tail[10] : half_reg) begin
               out_next = dwd_pkg::ONES;
            end else begin
               out_next = 10'h000;
            end
         end
         dwd_pkg::SEL_RSV: out_next = dwd_pkg::MID;
      endcase
   end

   // output holds while asleep; midscale until live data arrives
   always_ff @(posedge CLK) begin
      if (RESET) begin
         WAVE_OUT <= dwd_pkg::MID;
         out_live_reg <= 1'b0;
      end else if (run) begin
         out_live_reg <= tail[11] && !rst_bit; // see (R8)
         WAVE_OUT <= (tail[11] && !rst_bit) ? out_next : dwd_pkg::MID; // see (R13)
      end
   end

   // converter power-down is its own bit, independent of clock sleep
   always_ff @(posedge CLK) begin
      if (RESET) begin
         DAC_OFF <= 1'b0;
      end else begin
         DAC_OFF <= ctrl_reg[dwd_pkg::B_DSLP]; // see (R11)
      end
   end

   // ****************************************************************
   // read side
   // ****************************************************************
   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      unique case (a)
         dwd_pkg::A_WORD: rd_mux = {16'h0000, last_word_reg};
         dwd_pkg::A_CTRL: rd_mux = {16'h0000, ctrl_reg};
         dwd_pkg::A_TWA: rd_mux = {4'h0, tw_reg[0]};
         dwd_pkg::A_TWB: rd_mux = {4'h0, tw_reg[1]};
         dwd_pkg::A_PHA: rd_mux = {20'h00000, ph_reg[0]};
         dwd_pkg::A_PHB: rd_mux = {20'h00000, ph_reg[1]};
         dwd_pkg::A_ACC: rd_mux = {4'h0, acc_reg};
         default: rd_mux = 32'h00000000;
      endcase
   endfunction

   // one read in flight; answer the cycle after the address is taken
   always_ff @(posedge CLK) begin
      if (RESET) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= dwd_pkg::RESP_OK;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_mux({S_AXI_ARADDR[7:2], 2'h0});
         S_AXI_RRESP <= is_mapped({S_AXI_ARADDR[7:2], 2'h0}) ?
            dwd_pkg::RESP_OK : dwd_pkg::RESP_ERR;
      end else if (S_AXI_RVALID) begin
         S_AXI_RVALID <= !S_AXI_RREADY;
         S_AXI_ARREADY <= S_AXI_RREADY;
      end else begin
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   sequence s_low_write;
      dec_valid && dec_word[15:14] == dwd_pkg::DST_TWA && !ctrl_reg[dwd_pkg::B_FULL]
         && !ctrl_reg[dwd_pkg::B_HALF];
   endsequence
   property p_low_write;
      s_low_write |=>
         tw_reg[0][13:0] == $past(dec_word[13:0]);
   endproperty
   a_low_write: assert property (p_low_write) // see (R1)
      else $error("tuning word a low half not loaded");

   property p_ctrl_load;
      is_ctrl |=> ctrl_reg[dwd_pkg::B_FULL] == $past(dec_word[13]);
   endproperty
   a_ctrl_load: assert property (p_ctrl_load) // see (R3)
      else $error("control word full-width bit not taken");

   property p_phase_load;
      dec_valid && dec_word[15:13] == 3'h7 |=> ph_reg[1] == $past(dec_word[11:0]);
   endproperty
   a_phase_load: assert property (p_phase_load) // see (R6)
      else $error("phase offset b not loaded");

   property p_acc_clear;
      rst_bit && run |=> acc_reg == 28'h0000000;
   endproperty
   a_acc_clear: assert property (p_acc_clear) // see (R7)
      else $error("accumulator not cleared under reset bit");

   property p_sleep_hold;
      !run |=> $stable(acc_reg) && $stable(WAVE_OUT);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) // see (R10)
      else $error("state moved while clock asleep");

   sequence s_release;
      $fell(rst_bit) ##0 run[*7];
   endsequence
   property p_release_late;
      $fell(rst_bit) && run |-> (!out_live_reg)[*7];
   endproperty
   a_release_late: assert property (p_release_late) // see (R8)
      else $error("output live too early after reset release");
   property p_release_on;
      s_release ##0 !rst_bit |=> out_live_reg;
   endproperty
   a_release_on: assert property (p_release_on) // see (R8)
      else $error("output not live seven cycles after release");

   property p_bit_levels;
      out_live_reg && $past(run) && sel == dwd_pkg::SEL_BIT && $stable(sel) |->
         WAVE_OUT == dwd_pkg::ONES || WAVE_OUT == 10'h000;
   endproperty
   a_bit_levels: assert property (p_bit_levels) // see (R13)
      else $error("bit output not a full-swing level");

   property p_full_toggle;
      dec_valid && dec_word[15:14] == dwd_pkg::DST_TWB && ctrl_reg[dwd_pkg::B_FULL]
         |=> hi_flag_reg[1] != $past(hi_flag_reg[1]);
   endproperty
   a_full_toggle: assert property (p_full_toggle) // see (R20)
      else $error("half toggle did not flip");
endmodule

// *** tb/dwd_host_model.sv ***
// serial host model that frames sixteen-bit words onto the three-wire port
// assumes the core oversamples the pins; four clocks per serial clock phase
`timescale 1ns/10ps
module dwd_host_model (
   input wire logic clk,
   output logic sclk,
   output logic frame_sync_n_n,
   output logic serial_in
);
   // ****
   // frame driver
   // ****
   initial begin
      sclk = 1'b1;
      frame_sync_n_n = 1'b1;
      serial_in = 1'b0;
   end
   // sclk stands high between frames; data flips after a frame so no stale bit lingers
   task automatic send(input logic [15:0] w, input int n);
      int i;
      @(posedge clk);
      frame_sync_n_n <= 1'b0;
      for (i = 15; i > 15 - n; i--) begin
         serial_in <= w[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
      end
      repeat (4) @(posedge clk);
      frame_sync_n_n <= 1'b1;
      serial_in <= ~serial_in;
      repeat (8) @(posedge clk);
   endtask
endmodule

// *** tb/tb_dwd_top.sv ***
// self-checking bench: register reads over axi4-lite, words by bus and serial port
// assumes the package, the core and the host model are compiled first
`timescale 1ns/10ps
module tb_dwd_top;
   logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat, rdd, acc;
   logic [1:0] resp, br, rr;
   logic [9:0] wave, last;
   logic dac_off, awr, wrd, bv, arr, rv, sclk, fs_n, sd;
   int error_cnt = 0, comparisons = 0, chg;
   // ****
   // harness
   // ****
   always #4 clk = ~clk;
   dwd_host_model host (.clk(clk), .sclk(sclk), .frame_sync_n_n(fs_n), .serial_in(sd));
   dwd_top uut (.CLK(clk), .RESET(rst), .SCLK(sclk), .FRAME_SYNC_N_N(fs_n), .SERIAL_IN(sd),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rre), .WAVE_OUT(wave), .DAC_OFF(dac_off));
   task automatic close_out();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // a wait that runs out is a failure, so a hung slave cannot stall the run
   task automatic guard(input int n);
      if (n >= 500) begin
         error_cnt++;
         close_out();
      end
   endtask
   // write: both channels offered at once, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (!bv && n < 500);
      guard(n);
      resp = br;
      bre <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arr) arv <= 1'b0;
      end while (!rv && n < 500);
      guard(n);
      rdat = rdd;
      resp = rr;
      rre <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rdat, exp);
   endtask
   task automatic ww(input logic [15:0] w);
      wr(dwd_pkg::A_WORD, {16'h0000, w});
   endtask
   // lets the output settle, then counts its changes over sixteen cycles
   task automatic count_chg();
      repeat (12) @(posedge clk);
      chg = 0;
      @(negedge clk);
      last = wave;
      repeat (16) begin
         @(negedge clk);
         if (wave !== last) chg++;
         last = wave;
      end
      @(posedge clk);
   endtask
   // ****
   // scenarios
   // ****
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      rchk(dwd_pkg::A_CTRL, 32'h0000_0100);
      chk(wave, dwd_pkg::MID);
      host.send(16'h2100, 16);
      host.send(16'h4000, 16);
      host.send(16'h7FFF, 16);
      rchk(dwd_pkg::A_TWA, 32'h0FFF_C000);
      ww(16'h0100);
      ww(16'hBFFF);
      rchk(dwd_pkg::A_TWB, 32'h0000_3FFF);
      ww(16'h1100);
      ww(16'h40FF);
      rchk(dwd_pkg::A_TWA, 32'h003F_C000);
      ww(16'hE123);
      ww(16'hC456);
      rchk(dwd_pkg::A_PHB, 32'h0000_0123);
      rchk(dwd_pkg::A_PHA, 32'h0000_0456);
      ww(16'h0140);
      host.send(16'h0000, 8);
      rchk(dwd_pkg::A_CTRL, 32'h0000_0140);
      chk(dac_off, 1'b1);
      // tuning word b near half the accumulator range makes the msb toggle every cycle
      ww(16'h1100);
      ww(16'hA000);
      ww(16'h0828);
      count_chg();
      chk(chg > 12, 1'b1);
      chk(wave == 10'h000 || wave == dwd_pkg::ONES, 1'b1);
      ww(16'h0820);
      count_chg();
      chk(chg inside {[6:9]}, 1'b1);
      ww(16'h0822);
      count_chg();
      chk(wave, dwd_pkg::MID);
      // sleep in bit mode: a running clock would make the output toggle
      ww(16'h08A8);
      count_chg();
      chk(chg, 0);
      rd(dwd_pkg::A_ACC);
      acc = rdat;
      rchk(dwd_pkg::A_ACC, acc);
      ww(16'hC001);
      rchk(dwd_pkg::A_PHA, 32'h0000_0001);
      wr(8'h1C, 32'h0);
      chk(resp, dwd_pkg::RESP_ERR);
      rd(8'h1C);
      chk(resp, dwd_pkg::RESP_ERR);
      // wake under the reset bit; the running accumulator must read zero
      ww(16'h0100);
      rchk(dwd_pkg::A_ACC, 32'h0000_0000);
      ww(16'h4155);
      rchk(dwd_pkg::A_TWA, 32'h003F_C155);
      // full width zeroes tuning word b in two writes, so the phase stands still
      ww(16'h2100);
      ww(16'h8000);
      ww(16'h8000);
      rchk(dwd_pkg::A_TWB, 32'h0000_0000);
      ww(16'hC400);
      ww(16'h0800);
      count_chg();
      chk(wave, 10'h3FF);
      chk(dac_off, 1'b0);
      ww(16'h0C02);
      count_chg();
      chk(wave, 10'h091);
      close_out();
   end
endmodule
